/* mcc_misc_config.sv */
// misc clock configuration register and the logic its fields steer
// Operation
// RL1 - bit25 clear: calibration uses resampled reference
// RL2 - bit25 set: calibration uses original reference
// RL3 - bit24 set: events latch during boot
// RL4 - bit24 clear: events latch only after boot
// RL5 - slow filter ticks at 1MHz over 2^rate
// RL6 - rate 0..20, reset 0x10, shared by all dividers
// RL7 - start delay none..100s after accelerated calibration
// RL8 - startup 0: outputs wait for pll lock
// RL9 - startup 2: outputs ignore pll lock
// RL10 - sync bit aligns spreader 1 to spreader 0
// RL11 - priority bit picks preferred valid crystal
// RL12 - mode field forces primary, backup or auto
// RL13 - auto uses loss, short-term monitors and gpio
// RL14 - reserved bits read zero, writes ignored
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module mcc_misc_config #(
    parameter int TICK_CYCLES = mcc_pkg::TICK_CYC,
    parameter int MS_LEN = mcc_pkg::MS_TICKS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic refResampled,
    input wire logic refOriginal,
    input wire logic bootDone,
    input wire logic eventIn,
    input wire logic eventClear,
    input wire logic accelCalDone,
    input wire logic dcdSlowEnable,
    input wire logic analogPllLock,
    input wire logic sscSameFreq,
    input wire logic [1:0] xtalLos,
    input wire logic [1:0] xtalStOk,
    input wire logic [2:0] gpioFunc,
    input wire logic gpioXtalSel,
    output logic calRefClk,
    output logic eventLatched,
    output logic dcdUpdatePulse,
    output logic dcdSlowActive,
    output logic outputsEnable,
    output logic sscAlign,
    output logic xtalSelect,
    output logic [mcc_pkg::RATE_W-1:0] fodSlowRate
);
    logic [31:0] regQ;
    mcc_pkg::mcc_cfg_t cfg;
    assign cfg.refOrig = regQ[mcc_pkg::REF_SEL_BIT];
    assign cfg.bootEvt = regQ[mcc_pkg::BOOT_EVT_BIT];
    assign cfg.rate = regQ[mcc_pkg::RATE_LSB +: mcc_pkg::RATE_W];
    assign cfg.dly = regQ[mcc_pkg::DLY_LSB +: mcc_pkg::DLY_W];
    assign cfg.startup = regQ[mcc_pkg::START_LSB +: 2];
    assign cfg.sscSync = regQ[mcc_pkg::SYNC_BIT];
    assign cfg.xtalPri = regQ[mcc_pkg::PRI_BIT];
    assign cfg.xtalMode = regQ[mcc_pkg::MODE_LSB +: 2];

    // write channel: address and data accepted in either order
    logic awHeldQ, wHeldQ, bvalidQ;
    logic [11:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    assign s_axi_awready = !awHeldQ && !bvalidQ;
    assign s_axi_wready = !wHeldQ && !bvalidQ;
    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire awHave = awHeldQ || awTake;
    wire wHave = wHeldQ || wTake;
    wire [11:0] wrAddr = awHeldQ ? awAddrQ : s_axi_awaddr;
    wire [31:0] wrData = wHeldQ ? wDataQ : s_axi_wdata;
    wire [3:0] wrStrb = wHeldQ ? wStrbQ : s_axi_wstrb;
    wire doWrite = awHave && wHave && !bvalidQ;
    wire wrHit = (wrAddr == mcc_pkg::MISC_SETTINGS_OFS);

    function automatic logic [31:0] strbMask(input logic [3:0] s);
        strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    wire [31:0] laneMask = strbMask(wrStrb) & mcc_pkg::MISC_WMASK;
    wire [31:0] merged = (regQ & ~laneMask) | (wrData & laneMask);
    wire [4:0] newRate = merged[mcc_pkg::RATE_LSB +: mcc_pkg::RATE_W];
    wire [2:0] newDly = merged[mcc_pkg::DLY_LSB +: mcc_pkg::DLY_W];
    wire [1:0] newStart = merged[mcc_pkg::START_LSB +: 2];
    wire [1:0] newMode = merged[mcc_pkg::MODE_LSB +: 2];
    // out-of-range codes keep the old field value
    wire [31:0] regD = {merged[31:24],
        (newRate > mcc_pkg::RATE_MAX) ? cfg.rate : newRate, // [RL6]
        (newDly > mcc_pkg::DLY_MAX) ? cfg.dly : newDly,
        (newStart == mcc_pkg::START_WAIT || newStart == mcc_pkg::START_FREE)
            ? newStart : cfg.startup,
        merged[13:5],
        (newMode > mcc_pkg::MODE_AUTO) ? cfg.xtalMode : newMode,
        merged[2:0]};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            regQ <= mcc_pkg::MISC_RESET; // [RL6] [RL12]
        end else if (doWrite && wrHit) begin
            regQ <= regD & mcc_pkg::MISC_WMASK; // [RL14]
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            bvalidQ <= 1'b0;
            awAddrQ <= 12'h000;
            wDataQ <= 32'h0000_0000;
            wStrbQ <= 4'h0;
            s_axi_bresp <= mcc_pkg::RESP_OKAY;
        end else begin
            if (awTake) begin
                awAddrQ <= s_axi_awaddr;
            end
            if (wTake) begin
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            awHeldQ <= awHave && !doWrite;
            wHeldQ <= wHave && !doWrite;
            if (doWrite) begin
                bvalidQ <= 1'b1;
                s_axi_bresp <= wrHit ? mcc_pkg::RESP_OKAY : mcc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalidQ <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalidQ;

    // read channel
    logic rvalidQ;
    assign s_axi_arready = !rvalidQ;
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire [31:0] statusWord = {24'h00_0000, fodSlowRate[0], xtalSelect, sscAlign,
        outputsEnable, dcdSlowActive, eventLatched, calRefClk, bootDone};
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rvalidQ <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= mcc_pkg::RESP_OKAY;
        end else if (arTake) begin
            rvalidQ <= 1'b1;
            if (s_axi_araddr == mcc_pkg::MISC_SETTINGS_OFS) begin
                s_axi_rdata <= regQ;
                s_axi_rresp <= mcc_pkg::RESP_OKAY;
            end else if (s_axi_araddr == mcc_pkg::STATUS_OFS) begin
                s_axi_rdata <= statusWord;
                s_axi_rresp <= mcc_pkg::RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= mcc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalidQ <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalidQ;

    // reference select is a plain mux; clocks are glitch-prone, kept simple
    assign calRefClk = cfg.refOrig ? refOriginal : refResampled; // [RL1] [RL2]

    // event latch gated by boot state; set wins over clear
    wire latchAllowed = bootDone || cfg.bootEvt; // [RL3] [RL4]
    logic evtQ;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            evtQ <= 1'b0;
        end else if (eventIn && latchAllowed) begin
            evtQ <= 1'b1;
        end else if (eventClear) begin
            evtQ <= 1'b0;
        end
    end
    assign eventLatched = evtQ;

    // 1 MHz base tick then divide by 2^rate
    logic [7:0] preQ;
    logic [19:0] rateCntQ;
    logic [31:0] msCntQ;
    wire usTick = (preQ == 8'(TICK_CYCLES - 1));
    wire [19:0] rateLimit = 20'((21'h1 << cfg.rate) - 21'h1);
    wire rateTick = usTick && (rateCntQ >= rateLimit);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            preQ <= 8'h00;
            rateCntQ <= 20'h0_0000;
            dcdUpdatePulse <= 1'b0;
        end else begin
            preQ <= usTick ? 8'h00 : preQ + 8'h01;
            if (usTick) begin
                rateCntQ <= rateTick ? 20'h0_0000 : rateCntQ + 20'h0_0001;
            end
            dcdUpdatePulse <= rateTick && dcdSlowActive; // [RL5]
        end
    end
    assign fodSlowRate = cfg.rate; // [RL6]

    // slow-start delay: 10^(code-1) ms
    function automatic logic [31:0] delayMs(input logic [2:0] c);
        case (c)
            3'h1: delayMs = 32'd1;
            3'h2: delayMs = 32'd10;
            3'h3: delayMs = 32'd100;
            3'h4: delayMs = 32'd1000;
            3'h5: delayMs = 32'd10000;
            3'h6: delayMs = 32'd100000;
            default: delayMs = 32'd0;
        endcase
    endfunction
    wire [31:0] delayUs = delayMs(cfg.dly) * 32'(MS_LEN);
    mcc_pkg::mcc_dcd_t dcdQ;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dcdQ <= mcc_pkg::DCD_IDLE;
            msCntQ <= 32'h0000_0000;
        end else if (!dcdSlowEnable) begin
            dcdQ <= mcc_pkg::DCD_IDLE;
            msCntQ <= 32'h0000_0000;
        end else begin
            case (dcdQ)
                mcc_pkg::DCD_IDLE: begin
                    msCntQ <= 32'h0000_0000;
                    if (accelCalDone) begin
                        dcdQ <= (delayUs == 32'h0) ? mcc_pkg::DCD_SLOW : mcc_pkg::DCD_WAIT;
                    end
                end
                mcc_pkg::DCD_WAIT: begin
                    if (usTick) begin
                        msCntQ <= msCntQ + 32'h1;
                    end
                    if (msCntQ >= delayUs) begin
                        dcdQ <= mcc_pkg::DCD_SLOW; // [RL7]
                    end
                end
                mcc_pkg::DCD_SLOW: dcdQ <= mcc_pkg::DCD_SLOW;
                default: dcdQ <= mcc_pkg::DCD_IDLE;
            endcase
        end
    end
    assign dcdSlowActive = (dcdQ == mcc_pkg::DCD_SLOW);

    // startup gating of outputs, and spreader alignment
    assign outputsEnable = (cfg.startup == mcc_pkg::START_FREE) || analogPllLock; // [RL8] [RL9]
    assign sscAlign = cfg.sscSync && sscSameFreq; // [RL10]

    // crystal choice; automatic choice is made while boot runs, then held until the chosen crystal goes invalid or gpio mode is selected
    wire [1:0] xtalValid = ~xtalLos & xtalStOk;
    wire gpioMode = (gpioFunc == mcc_pkg::GPIO_XTAL_FUNC);
    wire autoPick = gpioMode ? gpioXtalSel : // [RL13]
        (&xtalValid) ? cfg.xtalPri : // [RL11]
        xtalValid[1] && !xtalValid[0];
    logic autoQ;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            autoQ <= 1'b0;
        end else if (!bootDone || !xtalValid[autoQ] || gpioMode) begin
            autoQ <= autoPick; // [RL13]
        end
    end
    assign xtalSelect = (cfg.xtalMode == mcc_pkg::MODE_PRI) ? 1'b0 : // [RL12]
        (cfg.xtalMode == mcc_pkg::MODE_BAK) ? 1'b1 : autoQ;

    // checks
    property p_reserved;
        @(posedge sys_clk) disable iff (!rstn) (regQ & ~mcc_pkg::MISC_WMASK) == 32'h0;
    endproperty
    reserved_zero_a: assert property (p_reserved) else $error("reserved bits set"); // [RL14]
    rate_range_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL6]
        cfg.rate <= mcc_pkg::RATE_MAX) else $error("rate out of range");
    boot_block_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL4]
        !bootDone && !cfg.bootEvt && !evtQ |=> !evtQ) else $error("event latched in boot");
    boot_allow_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL3]
        eventIn && cfg.bootEvt |=> evtQ) else $error("event lost");
    ref_sel_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL1]
        !regQ[mcc_pkg::REF_SEL_BIT] |-> calRefClk == refResampled) else $error("ref mux");
    ref_orig_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL2]
        regQ[mcc_pkg::REF_SEL_BIT] |-> calRefClk == refOriginal) else $error("orig ref mux");
    out_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL8]
        cfg.startup == mcc_pkg::START_WAIT && !analogPllLock |-> !outputsEnable)
        else $error("outputs before lock");
    out_free_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL9]
        cfg.startup == mcc_pkg::START_FREE |-> outputsEnable) else $error("outputs gated");
    ssc_align_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL10]
        !cfg.sscSync |-> !sscAlign) else $error("spreader aligned");
    xtal_force_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL12]
        cfg.xtalMode == mcc_pkg::MODE_BAK |-> xtalSelect) else $error("force backup");
    xtal_pri_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL11]
        !bootDone && !gpioMode && (&xtalValid) |=> autoQ == $past(cfg.xtalPri))
        else $error("priority");
    dcd_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL5]
        dcdUpdatePulse |-> dcdSlowActive || $past(dcdSlowActive)) else $error("pulse");
    dcd_nodelay_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [RL7]
        dcdSlowEnable && dcdQ == mcc_pkg::DCD_IDLE && accelCalDone && cfg.dly == 3'h0
        ##1 dcdSlowEnable |-> dcdSlowActive) else $error("no-delay start");
endmodule // mcc_misc_config

/* mcc_misc_config_tb.sv */
// self-checking testbench for the misc clock configuration register
`timescale 1ns/1ps
module mcc_misc_config_tb;
    localparam int TK = 2;
    localparam int MS = 2;
    localparam logic [1:0] OK = mcc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = mcc_pkg::RESP_SLVERR;
    localparam logic [11:0] A0 = mcc_pkg::MISC_SETTINGS_OFS;
    logic sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, xtalLos, xtalStOk;
    logic refResampled, refOriginal, bootDone, eventIn, eventClear, accelCalDone;
    logic dcdSlowEnable, analogPllLock, sscSameFreq, gpioXtalSel;
    logic [2:0] gpioFunc;
    logic calRefClk, eventLatched, dcdUpdatePulse, dcdSlowActive, outputsEnable;
    logic sscAlign, xtalSelect;
    logic [4:0] fodSlowRate, r;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [33:0] re;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;

    mcc_misc_config #(.TICK_CYCLES(TK), .MS_LEN(MS)) uut (
        .sys_clk(sys_clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .refResampled(refResampled), .refOriginal(refOriginal), .bootDone(bootDone),
        .eventIn(eventIn), .eventClear(eventClear), .accelCalDone(accelCalDone),
        .dcdSlowEnable(dcdSlowEnable), .analogPllLock(analogPllLock),
        .sscSameFreq(sscSameFreq), .xtalLos(xtalLos), .xtalStOk(xtalStOk),
        .gpioFunc(gpioFunc), .gpioXtalSel(gpioXtalSel), .calRefClk(calRefClk),
        .eventLatched(eventLatched), .dcdUpdatePulse(dcdUpdatePulse),
        .dcdSlowActive(dcdSlowActive), .outputsEnable(outputsEnable), .sscAlign(sscAlign),
        .xtalSelect(xtalSelect), .fodSlowRate(fodSlowRate));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] cf(input logic rf, bt, input logic [4:0] rt,
            input logic [2:0] dl, input logic [1:0] st, input logic sy, pr, input logic [1:0] md);
        return {6'h00, rf, bt, rt, dl, st, 6'h00, sy, pr, 1'b0, md, 3'h0};
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic hold(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // address and data offered together, each dropped once its own ready is seen
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad = 0;
        bit wd = 0;
        @(posedge sys_clk);
        bq.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge sys_clk);
            if (!ad && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge sys_clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad = 0;
        @(posedge sys_clk);
        rq.push_back({er, d});
        araddr <= a;
        arvalid <= 1'b1;
        while (!ad) begin
            @(posedge sys_clk);
            if (arready) begin
                ad = 1;
                arvalid <= 1'b0;
            end
        end
        while (!rvalid) @(posedge sys_clk);
    endtask

    task automatic pulse(input bit clr);
        @(posedge sys_clk);
        if (clr) eventClear <= 1'b1; else eventIn <= 1'b1;
        @(posedge sys_clk);
        if (clr) eventClear <= 1'b0; else eventIn <= 1'b0;
        hold(2);
    endtask

    // responses are paired with the oldest note; ready is held high throughout
    always @(posedge sys_clk) begin
        if (bvalid && bready) chk("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
        if (rvalid && rready) begin
            re = rq.pop_front();
            chk("rresp", {30'h0, rresp}, {30'h0, re[33:32]});
            chk("rdata", rdata, re[31:0]);
        end
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        rstn = 0; awaddr = 0; awvalid = 0; wdata = 0; wstrb = 4'hf; wvalid = 0; bready = 1;
        araddr = 0; arvalid = 0; rready = 1; refResampled = 0; refOriginal = 0; bootDone = 0;
        eventIn = 0; eventClear = 0; accelCalDone = 0; dcdSlowEnable = 0; analogPllLock = 0;
        sscSameFreq = 0; xtalLos = 2'h0; xtalStOk = 2'h3; gpioFunc = 3'h0; gpioXtalSel = 0;
        n = $urandom(19020);
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(A0, cf(0, 0, 5'h10, 3'h5, 2'h0, 0, 0, 2'h2), OK);
        rd(12'h008, 32'h0, ERR);
        wr(12'h00c, 32'hffff_ffff, ERR);
        wr(A0, 32'hffff_ffff, OK);
        // illegal codes in every field keep the old value; bits 1:0 sit outside this block
        rd(A0, 32'h0385_00d0 | {30'h0, mcc_pkg::MISC_WMASK[1:0]}, OK);
        wr(A0, cf(0, 0, 5'h10, 3'h5, 2'h0, 0, 0, 2'h2), OK);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            refResampled <= 1'($urandom);
            refOriginal <= 1'($urandom);
            if (i == 4) wr(A0, cf(1, 0, 5'h10, 3'h5, 2'h0, 0, 0, 2'h2), OK);
            hold(1);
            chk("calRefClk", {31'h0, calRefClk}, {31'h0, i < 4 ? refResampled : refOriginal});
        end
        wr(A0, cf(0, 0, 5'h10, 3'h5, 2'h0, 0, 0, 2'h2), OK);
        pulse(0);
        chk("eventLatched", {31'h0, eventLatched}, 32'h0);
        wr(A0, cf(0, 1, 5'h10, 3'h5, 2'h0, 0, 0, 2'h2), OK);
        pulse(0);
        chk("eventLatched", {31'h0, eventLatched}, 32'h1);
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            sscSameFreq <= 1'($urandom) | (k == 0);
            wr(A0, cf(0, 0, 5'h10, 3'h5, (k == 1) ? 2'h2 : 2'h0, k == 0, k == 2,
                (k < 2) ? 2'(k) : 2'h2), OK);
            hold(3);
            chk("outputsEnable", {31'h0, outputsEnable}, {31'h0, k == 1});
            chk("sscAlign", {31'h0, sscAlign}, {31'h0, (k == 0) && sscSameFreq});
            chk("xtalSelect", {31'h0, xtalSelect}, {31'h0, k == 1 || k == 2});
        end
        @(posedge sys_clk);
        gpioFunc <= mcc_pkg::GPIO_XTAL_FUNC;
        gpioXtalSel <= 1'b1;
        analogPllLock <= 1'b1;
        hold(3);
        chk("xtalSelect", {31'h0, xtalSelect}, 32'h1);
        chk("outputsEnable", {31'h0, outputsEnable}, 32'h1);
        @(posedge sys_clk);
        gpioFunc <= 3'h0;
        xtalLos <= 2'h1;
        hold(3);
        chk("xtalSelect", {31'h0, xtalSelect}, 32'h1);
        r = 5'($urandom % 21);
        wr(A0, cf(0, 0, r, 3'h0, 2'h0, 0, 0, 2'h2), OK);
        wr(A0, cf(0, 0, 5'h15, 3'h0, 2'h0, 0, 0, 2'h2), OK);
        hold(1);
        chk("fodSlowRate", {27'h0, fodSlowRate}, {27'h0, r});
        wr(A0, cf(0, 0, 5'h02, 3'h0, 2'h0, 0, 0, 2'h2), OK);
        @(posedge sys_clk);
        dcdSlowEnable <= 1'b1;
        accelCalDone <= 1'b1;
        hold(8);
        chk("dcdSlowActive", {31'h0, dcdSlowActive}, 32'h1);
        n = 0;
        while (!dcdUpdatePulse && n < 100) begin
            hold(1);
            n++;
        end
        n = 0;
        do begin
            hold(1);
            n++;
        end while (!dcdUpdatePulse && n < 100);
        chk("pulseGap", 32'(n), 32'(TK * 4));
        // only byte lane 2 lands: rate 2, start delay code 1
        @(posedge sys_clk);
        dcdSlowEnable <= 1'b0;
        wstrb <= 4'h4;
        wr(A0, 32'hff11_ffff, OK);
        rd(A0, cf(0, 0, 5'h02, 3'h1, 2'h0, 0, 0, 2'h2), OK);
        @(posedge sys_clk);
        wstrb <= 4'hf;
        dcdSlowEnable <= 1'b1;
        hold(2);
        chk("dcdSlowActive", {31'h0, dcdSlowActive}, 32'h0);
        hold(8);
        chk("dcdSlowActive", {31'h0, dcdSlowActive}, 32'h1);
        pulse(1);
        chk("eventLatched", {31'h0, eventLatched}, 32'h0);
        @(posedge sys_clk);
        bootDone <= 1'b1;
        pulse(0);
        chk("eventLatched", {31'h0, eventLatched}, 32'h1);
        rd(mcc_pkg::STATUS_OFS, {24'h00_0000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1,
            refResampled, 1'b1}, OK);
        // let the response monitor see the last answer before the run ends
        hold(2);
        give_verdict();
    end
endmodule // mcc_misc_config_tb

/* mcc_pkg.sv */
// package for the misc clock configuration register block
package mcc_pkg;
    localparam logic [11:0] MISC_SETTINGS_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [31:0] MISC_RESET = 32'h0085_0010;
    localparam logic [31:0] MISC_WMASK = 32'h03ff_c0db;
    localparam int REF_SEL_BIT = 25;
    localparam int BOOT_EVT_BIT = 24;
    localparam int RATE_LSB = 19;
    localparam int RATE_W = 5;
    localparam int DLY_LSB = 16;
    localparam int DLY_W = 3;
    localparam int START_LSB = 14;
    localparam int SYNC_BIT = 7;
    localparam int PRI_BIT = 6;
    localparam int MODE_LSB = 3;
    localparam logic [4:0] RATE_MAX = 5'h14;
    localparam logic [4:0] RATE_RESET = 5'h10;
    localparam logic [2:0] DLY_MAX = 3'h6;
    localparam logic [1:0] START_WAIT = 2'h0;
    localparam logic [1:0] START_FREE = 2'h2;
    localparam logic [1:0] MODE_PRI = 2'h0;
    localparam logic [1:0] MODE_BAK = 2'h1;
    localparam logic [1:0] MODE_AUTO = 2'h2;
    localparam logic [2:0] GPIO_XTAL_FUNC = 3'h6;
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_HZ = 1_000_000;
    localparam int TICK_CYC = CLK_HZ / TICK_HZ;
    localparam int MS_TICKS = 1000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic refOrig;
        logic bootEvt;
        logic [4:0] rate;
        logic [2:0] dly;
        logic [1:0] startup;
        logic sscSync;
        logic xtalPri;
        logic [1:0] xtalMode;
    } mcc_cfg_t;
    typedef enum logic [2:0] {
        DCD_IDLE = 3'b001,
        DCD_WAIT = 3'b010,
        DCD_SLOW = 3'b100
    } mcc_dcd_t;
endpackage
